// ==== dpram_host_pkg.sv ====
// Constants, timing counts and state codes for the dual-port RAM port controller
// How it works
// - A write ends when write strobe rises while the port or semaphore select is still low.
// - A read is held long enough for data written by the far port to flow through.
// - Reads assert port or semaphore select and output enable together and wait the access delay.
// - Write strobe waits the settle time; array writes also wait until busy shows no contention.
// - Semaphore access: semaphore select low, port select high, three address bits used.
package dpram_host_pkg;

    localparam int CLOCK_PERIOD_NS = 25;
    localparam int ACCESS_NS = 25;
    localparam int SETUP_NS = 15;
    localparam int WRITE_PULSE_NS = 20;
    localparam int SETTLE_NS = 20;
    localparam int RECOVER_NS = 15;
    localparam int FLOW_NS = 20;
    localparam int SYNC_STAGES = 2;
    localparam int SEM_INDEX_W = 3;
    localparam int CNT_W = 4;

    // Least times round up, never below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACCESS_CYC = min_cycles(ACCESS_NS);
    localparam int FLOW_CYC = min_cycles(FLOW_NS);
    localparam int SETTLE_CYC = min_cycles(SETTLE_NS);
    localparam int RECOVER_CYC = min_cycles(RECOVER_NS);
    localparam int PULSE_CYC = (min_cycles(WRITE_PULSE_NS) > min_cycles(SETUP_NS)) ?
        min_cycles(WRITE_PULSE_NS) : min_cycles(SETUP_NS);
    localparam int READ_HOLD_CYC = ACCESS_CYC + FLOW_CYC + SYNC_STAGES;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETTLE = 3'h1,
        ST_STROBE = 3'h3,
        ST_RELEASE = 3'h2,
        ST_RECOVER = 3'h6
    } phase_e;

endpackage

// ==== dpram_port_host.sv ====
// Controller driving one port of an asynchronous dual-port RAM
`timescale 1ns/1ps
module dpram_port_host
    import dpram_host_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 14
)(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Command side
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_semaphore,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic [1:0] cmd_lanes,
    // Answer side
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic mailbox_pending,
    output logic port_busy,
    // RAM port pins
    output logic select_n,
    output logic write_n,
    output logic read_enable_n,
    output logic semaphore_select_n,
    output logic upper_lane_select_n,
    output logic lower_lane_select_n,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic busy_n_in,
    input wire logic interrupt_n_in
);

    localparam int LOW_W = DATA_W / 2;

    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < DATA_W; i++)
            m[i] = (i < LOW_W) ? lanes[0] : lanes[1];
        return m;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic busy_meta_q, busy_free_q, int_meta_q, int_pending_q;
    logic [DATA_W-1:0] data_meta_q, data_sync_q;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            busy_meta_q <= 1'b1;
            busy_free_q <= 1'b1;
            int_meta_q <= 1'b1;
            int_pending_q <= 1'b0;
            data_meta_q <= '0;
            data_sync_q <= '0;
        end
        else
        begin
            busy_meta_q <= busy_n_in;
            busy_free_q <= busy_meta_q;
            int_meta_q <= interrupt_n_in;
            int_pending_q <= ~int_meta_q;
            data_meta_q <= data_in;
            data_sync_q <= data_meta_q;
        end
    end

    assign mailbox_pending = int_pending_q;
    assign port_busy = ~busy_free_q;

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    phase_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic is_write_q, is_write_d, is_sem_q, is_sem_d;
    logic [1:0] lanes_q, lanes_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic sel_n_q, sel_n_d, wr_n_q, wr_n_d, oe_n_q, oe_n_d, sem_n_q, sem_n_d;
    logic up_n_q, up_n_d, lo_n_q, lo_n_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] dout_q, dout_d, doe_q, doe_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        is_write_d = is_write_q;
        is_sem_d = is_sem_q;
        lanes_d = lanes_q;
        rsp_valid_d = 1'b0;
        rdata_d = rdata_q;
        sel_n_d = sel_n_q;
        wr_n_d = wr_n_q;
        oe_n_d = oe_n_q;
        sem_n_d = sem_n_q;
        up_n_d = up_n_q;
        lo_n_d = lo_n_q;
        addr_d = addr_q;
        dout_d = dout_q;
        doe_d = doe_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    is_write_d = cmd_write;
                    is_sem_d = cmd_semaphore;
                    lanes_d = cmd_lanes;
                    if (cmd_semaphore)
                    begin
                        // Port select and both lanes stay high during a semaphore cycle
                        addr_d = {{(ADDR_W-SEM_INDEX_W){1'b0}}, cmd_addr[SEM_INDEX_W-1:0]};
                        sem_n_d = 1'b0;
                    end
                    else
                    begin
                        addr_d = cmd_addr;
                        sel_n_d = 1'b0;
                        up_n_d = ~cmd_lanes[1];
                        lo_n_d = ~cmd_lanes[0];
                    end
                    if (cmd_write)
                    begin
                        dout_d = cmd_wdata;
                        doe_d = cmd_semaphore ? {DATA_W{1'b1}} : lane_mask(cmd_lanes);
                        cnt_d = CNT_W'(SETTLE_CYC - 1);
                        state_d = ST_SETTLE;
                    end
                    else
                    begin
                        oe_n_d = 1'b0;
                        cnt_d = CNT_W'(READ_HOLD_CYC - 1);
                        state_d = ST_STROBE;
                    end
                end
            end
            ST_SETTLE:
            begin
                // Strobe held off for the settle count; array writes also wait until busy shows the port free
                if (cnt_q != '0)
                    cnt_d = cnt_q - 1'b1;
                else if (busy_free_q || is_sem_q)
                begin
                    wr_n_d = 1'b0;
                    cnt_d = CNT_W'(PULSE_CYC - 1);
                    state_d = ST_STROBE;
                end
            end
            ST_STROBE:
            begin
                if (is_write_q)
                begin
                    if (cnt_q != '0)
                        cnt_d = cnt_q - 1'b1;
                    else
                    begin
                        wr_n_d = 1'b1;
                        state_d = ST_RELEASE;
                    end
                end
                else if (!busy_free_q && !is_sem_q)
                begin
                    // Lost arbitration: data not trusted, restart the hold
                    cnt_d = CNT_W'(READ_HOLD_CYC - 1);
                end
                else if (cnt_q != '0)
                    cnt_d = cnt_q - 1'b1;
                else
                begin
                    rdata_d = is_sem_q ? data_sync_q : (data_sync_q & lane_mask(lanes_q));
                    rsp_valid_d = 1'b1;
                    oe_n_d = 1'b1;
                    state_d = ST_RELEASE;
                end
            end
            ST_RELEASE:
            begin
                rsp_valid_d = is_write_q;
                sel_n_d = 1'b1;
                sem_n_d = 1'b1;
                up_n_d = 1'b1;
                lo_n_d = 1'b1;
                doe_d = '0;
                cnt_d = CNT_W'(RECOVER_CYC - 1);
                state_d = ST_RECOVER;
            end
            ST_RECOVER:
            begin
                // Gap also gives the semaphore the deselect time before a read-back
                if (cnt_q != '0)
                    cnt_d = cnt_q - 1'b1;
                else
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            is_write_q <= 1'b0;
            is_sem_q <= 1'b0;
            lanes_q <= 2'h0;
            rsp_valid_q <= 1'b0;
            rdata_q <= '0;
            sel_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            sem_n_q <= 1'b1;
            up_n_q <= 1'b1;
            lo_n_q <= 1'b1;
            addr_q <= '0;
            dout_q <= '0;
            doe_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            is_write_q <= is_write_d;
            is_sem_q <= is_sem_d;
            lanes_q <= lanes_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q <= rdata_d;
            sel_n_q <= sel_n_d;
            wr_n_q <= wr_n_d;
            oe_n_q <= oe_n_d;
            sem_n_q <= sem_n_d;
            up_n_q <= up_n_d;
            lo_n_q <= lo_n_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
        end
    end

    assign cmd_ready = (state_q == ST_IDLE);
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign select_n = sel_n_q;
    assign write_n = wr_n_q;
    assign read_enable_n = oe_n_q;
    assign semaphore_select_n = sem_n_q;
    assign upper_lane_select_n = up_n_q;
    assign lower_lane_select_n = lo_n_q;
    assign addr_out = addr_q;
    assign data_out = dout_q;
    assign data_oe = doe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence write_end_s;
        $rose(wr_n_q) && (!sel_n_q || !sem_n_q);
    endsequence
    sequence deselect_s;
        sel_n_q && sem_n_q && (doe_q == '0);
    endsequence
    a_write_end_order: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(wr_n_q) |-> write_end_s ##1 deselect_s)
        else $error("write strobe did not end the write before deselect");
    a_read_flow_hold: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(oe_n_q) |-> (!oe_n_q && (!sel_n_q || !sem_n_q))[*4])
        else $error("read released before access and flowthrough time");
    a_read_no_drive: assert property (@(posedge clock) disable iff (!reset_n)
        (!oe_n_q || rsp_valid_q && !is_write_q) |-> (doe_q == '0) && wr_n_q)
        else $error("data driven during a read");
    // Select has stood one settle cycle when the strobe falls
    a_write_after_settle: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(wr_n_q) && !sel_n_q |-> $past(busy_free_q) && !$past(sel_n_q))
        else $error("write strobe started before busy settled");
    a_sem_select_only: assert property (@(posedge clock) disable iff (!reset_n)
        !sem_n_q |-> sel_n_q && up_n_q && lo_n_q && (addr_q[ADDR_W-1:SEM_INDEX_W] == '0))
        else $error("semaphore access with array select or lanes");
    a_lane_gate: assert property (@(posedge clock) disable iff (!reset_n)
        sem_n_q && (doe_q != '0) |-> (doe_q == lane_mask({~up_n_q, ~lo_n_q})))
        else $error("data driven on an unselected lane");
    a_never_both: assert property (@(posedge clock) disable iff (!reset_n)
        !(!sel_n_q && !sem_n_q))
        else $error("array and semaphore selected together");

endmodule

// ==== dpram_device_model.sv ====
// Behavioural model of the dual-port RAM as seen from the left port
`timescale 1ns/1ps
module dpram_device_model #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 14
)(
    // Clock only paces the idle bus pattern
    input wire logic clock,
    // Left port pins
    input wire logic select_n,
    input wire logic write_n,
    input wire logic read_enable_n,
    input wire logic semaphore_select_n,
    input wire logic upper_lane_select_n,
    input wire logic lower_lane_select_n,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [DATA_W-1:0] data_oe,
    output logic [DATA_W-1:0] data_in,
    output logic busy_n_in,
    output logic interrupt_n_in,
    // Far port holds the contended location
    input wire logic far_hold
);
    localparam int H = DATA_W / 2;
    localparam logic [ADDR_W-1:0] RIGHT_MB = '1;
    localparam logic [ADDR_W-1:0] LEFT_MB = RIGHT_MB - 1'b1;
    // Owner codes: 0 free, 1 left, 2 right
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [1:0] owner [8];
    logic [1:0] pend [8];
    logic left_int = 1'b0;
    logic right_int = 1'b0;
    logic idle_t = 1'b0;
    logic [DATA_W-1:0] sem_out = '1;
    logic [DATA_W-1:0] mask, drive;
    // Strict compares keep power-up unknowns from faking a strobe edge
    wire wr_arr = (write_n === 1'b0) && (select_n === 1'b0) && (semaphore_select_n === 1'b1);
    wire rd_arr = (write_n === 1'b1) && (select_n === 1'b0) && (read_enable_n === 1'b0) && (semaphore_select_n === 1'b1);
    wire wr_sem = (write_n === 1'b0) && (semaphore_select_n === 1'b0) && (select_n === 1'b1);
    wire rd_sem = (write_n === 1'b1) && (semaphore_select_n === 1'b0) && (read_enable_n === 1'b0) && (select_n === 1'b1);
    initial
    begin
        foreach (mem[i]) mem[i] = '0;
        foreach (owner[i]) owner[i] = 2'd0;
        foreach (pend[i]) pend[i] = 2'd0;
    end
    task automatic sem_write(input logic [1:0] me, input logic [2:0] i, input logic v);
        if (v == 1'b0 && owner[i] == 2'd0) owner[i] = me;
        else if (v == 1'b0 && owner[i] != me) pend[i] = me;
        else if (v == 1'b1 && owner[i] == me)
        begin
            owner[i] = pend[i];
            pend[i] = 2'd0;
        end
        else if (v == 1'b1 && pend[i] == me) pend[i] = 2'd0;
    endtask
    // Far port never loses arbitration here, so its writes to the left mailbox always flag
    task automatic far_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        mem[a] = d;
        if (a == LEFT_MB) left_int = 1'b1;
    endtask
    task automatic far_sem(input logic [2:0] i, input logic v);
        sem_write(2'd2, i, v);
    endtask
    always @(posedge clock) idle_t <= ~idle_t;
    always @(negedge wr_arr)
    begin
        mem[addr_out] = (mem[addr_out] & ~mask) | (data_out & mask);
        if (addr_out == RIGHT_MB && busy_n_in) right_int = 1'b1;
    end
    always @(negedge rd_arr)
        if (addr_out == LEFT_MB && busy_n_in) left_int = 1'b0;
    always @(negedge wr_sem) sem_write(2'd1, addr_out[2:0], data_out[0]);
    // Latched at read start so a far write cannot disturb it
    always @(posedge rd_sem) sem_out = {DATA_W{owner[addr_out[2:0]] != 2'd1}};
    // Released lines toggle every cycle rather than keep old data
    always_comb
    begin
        mask = {{H{~upper_lane_select_n}}, {H{~lower_lane_select_n}}};
        if (rd_sem) drive = sem_out;
        else if (rd_arr) drive = (mem[addr_out] & mask) | ({H{idle_t, ~idle_t}} & ~mask);
        else drive = {H{idle_t, ~idle_t}};
        data_in = (data_oe & data_out) | (~data_oe & drive);
    end
    assign busy_n_in = ~far_hold;
    assign interrupt_n_in = ~left_int;
endmodule

// ==== dpram_port_host_tb_top.sv ====
// Self-checking bench for the dual-port RAM port controller
`timescale 1ns/1ps
module dpram_port_host_tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_semaphore = 1'b0;
    logic [13:0] cmd_addr = 14'h0;
    logic [17:0] cmd_wdata = 18'h0;
    logic [1:0] cmd_lanes = 2'h0;
    logic far_hold = 1'b0;
    logic cmd_ready, rsp_valid, mailbox_pending, port_busy, busy_n_in, interrupt_n_in;
    logic select_n, write_n, read_enable_n, semaphore_select_n, upper_lane_select_n, lower_lane_select_n;
    logic [13:0] addr_out;
    logic [17:0] rsp_rdata, data_out, data_oe, data_in;
    logic [31:0] seed = 32'h8c214ca9;
    logic [17:0] shadow [16384];
    int failures = 0;
    int comparisons = 0;
    int busy_strobes = 0;
    always #12.5 clock = ~clock;
    always @(posedge clock) if (write_n === 1'b0 && far_hold) busy_strobes <= busy_strobes + 1;
    dpram_port_host #(.DATA_W(18), .ADDR_W(14)) u_dut (.clock(clock), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_semaphore(cmd_semaphore),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_lanes(cmd_lanes), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mailbox_pending(mailbox_pending), .port_busy(port_busy),
        .select_n(select_n), .write_n(write_n), .read_enable_n(read_enable_n),
        .semaphore_select_n(semaphore_select_n), .upper_lane_select_n(upper_lane_select_n),
        .lower_lane_select_n(lower_lane_select_n), .addr_out(addr_out), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .busy_n_in(busy_n_in), .interrupt_n_in(interrupt_n_in));
    dpram_device_model #(.DATA_W(18), .ADDR_W(14)) u_dev (.clock(clock), .select_n(select_n),
        .write_n(write_n), .read_enable_n(read_enable_n), .semaphore_select_n(semaphore_select_n),
        .upper_lane_select_n(upper_lane_select_n), .lower_lane_select_n(lower_lane_select_n),
        .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .busy_n_in(busy_n_in), .interrupt_n_in(interrupt_n_in), .far_hold(far_hold));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [17:0] lanes_of(input logic [17:0] v, input logic [1:0] l);
        return v & {{9{l[1]}}, {9{l[0]}}};
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic timed_out(input string what);
        failures++;
        $display("CHECK FAILED at %0t: no %s", $time, what);
        print_verdict();
    endtask
    task automatic issue(input logic w, input logic s, input logic [13:0] a, input logic [17:0] d,
        input logic [1:0] l);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 40);
        if (cmd_ready !== 1'b1) timed_out("ready");
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_semaphore <= s;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_lanes <= l;
        @(posedge clock);
        cmd_valid <= 1'b0;
    endtask
    task automatic await_rsp(input int lim, output logic got);
        got = 1'b0;
        for (int n = 0; n < lim && !got; n++)
        begin
            @(posedge clock);
            #1;
            got = (rsp_valid === 1'b1);
        end
    endtask
    task automatic xfer(input logic w, input logic s, input logic [13:0] a, input logic [17:0] d,
        input logic [1:0] l);
        logic got;
        issue(w, s, a, d, l);
        await_rsp(20, got);
        if (!got) timed_out("answer");
    endtask
    task automatic wait_pending(input logic v);
        for (int n = 0; n < 8 && mailbox_pending !== v; n++) @(posedge clock);
        if (mailbox_pending !== v) timed_out("flag change");
    endtask
    initial
    begin
        logic [13:0] a;
        logic [17:0] d;
        logic [1:0] l;
        logic got;
        foreach (shadow[i]) shadow[i] = 18'h0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        #1;
        check({11'h0, cmd_ready, select_n, write_n, read_enable_n, semaphore_select_n,
            upper_lane_select_n, lower_lane_select_n}, 18'h7f, "idle pins");
        check(data_oe, 18'h0, "idle drive");
        // ----------------------------------------
        // Random array traffic, lane patterns 00 to 11
        // ----------------------------------------
        for (int i = 0; i < 40; i++)
        begin
            a = 14'(rnd() % 8) | (i[0] ? 14'h3ff0 : 14'h0);
            d = 18'(rnd());
            l = 2'(rnd());
            xfer(1'b1, 1'b0, a, d, l);
            shadow[a] = (shadow[a] & ~lanes_of('1, l)) | lanes_of(d, l);
            l = 2'(rnd());
            xfer(1'b0, 1'b0, a, 18'h0, l);
            check(rsp_rdata, lanes_of(shadow[a], l), "array read");
        end
        u_dev.far_write(14'h3ffe, 18'h1a5c3);
        wait_pending(1'b1);
        xfer(1'b0, 1'b0, 14'h3fff, 18'h0, 2'h3);
        check({17'h0, mailbox_pending}, 18'h1, "flag after far box read");
        xfer(1'b0, 1'b0, 14'h3ffe, 18'h0, 2'h3);
        check(rsp_rdata, 18'h1a5c3, "own box message");
        wait_pending(1'b0);
        xfer(1'b1, 1'b0, 14'h3fff, 18'h2b00d, 2'h3);
        check({17'h0, u_dev.right_int}, 18'h1, "far flag");
        // Write must stall while the far port holds the location
        far_hold <= 1'b1;
        repeat (4) @(posedge clock);
        issue(1'b1, 1'b0, 14'h0010, 18'h2f0f1, 2'h3);
        await_rsp(12, got);
        check({17'h0, got}, 18'h0, "write done under busy");
        check({17'h0, port_busy}, 18'h1, "busy seen");
        check(18'(busy_strobes), 18'h0, "strobe under busy");
        far_hold <= 1'b0;
        await_rsp(20, got);
        check({17'h0, got}, 18'h1, "write after busy");
        xfer(1'b0, 1'b0, 14'h0010, 18'h0, 2'h3);
        check(rsp_rdata, 18'h2f0f1, "data after busy");
        // A read under busy keeps restarting its hold until busy clears
        far_hold <= 1'b1;
        repeat (4) @(posedge clock);
        issue(1'b0, 1'b0, 14'h0010, 18'h0, 2'h1);
        await_rsp(12, got);
        check({17'h0, got}, 18'h0, "read done under busy");
        far_hold <= 1'b0;
        await_rsp(20, got);
        check({17'h0, got}, 18'h1, "read after busy");
        check(rsp_rdata, 18'h000f1, "low lane after busy");
        for (int k = 0; k < 8; k++)
        begin
            a = {11'(rnd()), 3'(k)};
            u_dev.far_sem(3'(k), 1'b0);
            xfer(1'b1, 1'b1, a, 18'(rnd()) & 18'h3fffe, 2'(rnd()));
            xfer(1'b0, 1'b1, a, 18'h0, 2'h0);
            check(rsp_rdata, 18'h3ffff, "token held far");
            u_dev.far_sem(3'(k), 1'b1);
            xfer(1'b0, 1'b1, a ^ 14'h3ff8, 18'h0, 2'h0);
            check(rsp_rdata, 18'h0, "token handed over");
            xfer(1'b1, 1'b1, a, 18'(rnd()) | 18'h1, 2'h0);
            xfer(1'b0, 1'b1, a, 18'h0, 2'h0);
            check(rsp_rdata, 18'h3ffff, "token freed");
        end
        print_verdict();
    end
endmodule
